/* logic/flag_pkg.sv */
// package: register map, field positions and carrier types of the status-flag block
package flag_pkg;
	// register indices (printed offsets are not all multiples of four)
	localparam logic [7:0] TASK1_STATUS_IDX = 8'h0B;
	localparam logic [7:0] TASK2_STATUS_IDX = 8'h0D;
	localparam logic [7:0] AXIS1_STATUS_IDX = 8'h10;
	localparam logic [7:0] AXIS2_STATUS_IDX = 8'h13;
	// own control, config and error register indices
	localparam logic [7:0] TASK1_CTRL_IDX = 8'h20;
	localparam logic [7:0] TASK2_CTRL_IDX = 8'h21;
	localparam logic [7:0] AXIS1_CTRL_IDX = 8'h22;
	localparam logic [7:0] AXIS2_CTRL_IDX = 8'h23;
	localparam logic [7:0] CONFIG_IDX = 8'h24;
	localparam logic [7:0] ERROR_IDX = 8'h25;
	localparam int ADDR_SHIFT = 2;

	// task status word fields
	localparam int TSK_ADDR_DONE_BIT = 12;
	localparam int TSK_TEACH_DONE_BIT = 13;
	localparam int TSK_TEACH_ERR_BIT = 14;
	localparam int TSK_ADDR_OVER_BIT = 15;
	// axis status word fields
	localparam int AX_REF_ORIGIN_BIT = 0;
	localparam int AX_BUSY_BIT = 1;
	localparam int AX_SERVO_LOCK_BIT = 2;
	localparam int AX_NO_ORIGIN_BIT = 3;
	localparam int AX_OPERATING_BIT = 4;
	localparam int AX_POS_DONE_BIT = 5;

	// task control register fields
	localparam int TC_TEACH_BIT = 0;
	localparam int TC_ADDR_SET_BIT = 1;
	localparam int TC_ADDR_LSB = 16;
	localparam int TC_ADDR_MSB = 26;
	// config register fields
	localparam int CFG_POS_ADDR_LSB = 0;
	localparam int CFG_POS_ADDR_MSB = 10;
	localparam int CFG_ORIGIN_AT_PON_BIT = 16;
	localparam int CFG_ABS_AXIS1_BIT = 17;
	localparam int CFG_ABS_AXIS2_BIT = 18;

	localparam logic [10:0] TEACH_ADDR_MAX = 11'h7CF;
	localparam int NUM_MANUAL_CMDS = 9;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// manual command bits of an axis control register, one-hot
	typedef enum logic [3:0] {
		CMD_ORIGIN_SEARCH,
		CMD_ORIGIN_RETURN,
		CMD_JOG,
		CMD_SERVO_LOCK,
		CMD_SERVO_FREE,
		CMD_POS_PRESET,
		CMD_ABS_INIT,
		CMD_ABS_SOFT_RESET,
		CMD_PULSE_GEN
	} manual_cmd_type;
	localparam int AC_START_POS_BIT = 16;
	localparam int AC_UNDEFINE_BIT = 17;
	localparam int AC_COORD_CHANGE_BIT = 18;

	// motion-core events for one axis
	typedef struct packed {
		logic at_ref_origin;
		logic in_position;
		logic target_reached;
		logic moving;
		logic interrupted;
		logic search_ok;
		logic search_fault;
		logic abs_read_ok;
		logic abs_read_fail;
		logic preset_done;
	} axis_event_type;

	typedef struct packed {
		logic busy;
		manual_cmd_type cmd;
		logic servo_lock;
		logic no_origin;
		logic operating;
		logic pos_done;
		logic positioning;
	} axis_state_type;

	typedef struct packed {
		logic teach_done;
		logic addr_done;
		logic teach_err;
		logic addr_over;
	} task_state_type;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} apb_resp_type;
endpackage : flag_pkg

/* logic/status_flags.sv */
// status-flag logic for two teach tasks and two axes, APB register access
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
// Operation
// [RULE_01] teaching error also sets teaching completed and address-set completed together
// [RULE_02] teach with origin unfixed or address above 1999 is a teaching error
// [RULE_03] teaching error clears only on a later error-free teach or address set
// [RULE_04] teach with position address out of range sets address over and teaching completed
// [RULE_05] address over clears on next normal address set or teach
// [RULE_06] reference origin flag follows at-origin and in-position
// [RULE_07] busy rises while any of nine manual commands executes
// [RULE_08] busy holds until the command bit drops; host must drop it
// [RULE_09] while busy, further manual commands are refused
// [RULE_10] servo lock flag shows servo lock active
// [RULE_11] positioning start without servo lock reports an error
// [RULE_12] no-origin set at power-up, abs read fail, search fault, undefine function
// [RULE_13] no-origin cleared by abs read, origin at power-up, search, preset, coordinate change
// [RULE_14] origin return while no-origin set reports an error
// [RULE_15] operating flag follows movement command output
// [RULE_16] positioning completed sets at target inside in-position range
// [RULE_17] positioning completed stays latched until next positioning starts
// [RULE_18] interrupted positioning inside range still sets completed
// [RULE_19] pulse-generator operation sets completed whenever in position
// [RULE_20] positioning start clears completed as operating rises
// [RULE_21] six axis flags in bits 0 to 5 of each axis word
// [RULE_22] teaching error bit 14, address over bit 15 in each task word
// [RULE_23] teaching completed clears when teach request drops
module status_flags (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic pready_out,
	output logic [31:0] prdata_out,
	output logic pslverr_out,
	// motion core events, same clock
	input flag_pkg::axis_event_type axis_event_in [2],
	// axis drive outputs
	output logic [1:0] run_cmd_out,
	output logic [1:0] servo_loop_out
);
	typedef struct packed {
		flag_pkg::task_state_type [1:0] tsk;
		flag_pkg::axis_state_type [1:0] ax;
		logic [1:0][31:0] tctrl;
		logic [1:0][31:0] actrl;
		logic [31:0] cfg;
		logic [1:0] origin_ret_err;
		logic [1:0] servo_off_err;
		logic [1:0] refused;
		logic pon_pending;
		flag_pkg::apb_resp_type resp;
	} state_type;

	state_type cur_ff;
	state_type nxt_cur;

	function automatic logic [15:0] task_word(input flag_pkg::task_state_type t);
		logic [15:0] w;
		w = flag_pkg::WORD_RESET;
		w[flag_pkg::TSK_ADDR_DONE_BIT] = t.addr_done;
		w[flag_pkg::TSK_TEACH_DONE_BIT] = t.teach_done;
		w[flag_pkg::TSK_TEACH_ERR_BIT] = t.teach_err; // RULE_22
		w[flag_pkg::TSK_ADDR_OVER_BIT] = t.addr_over; // RULE_22
		return w;
	endfunction : task_word

	function automatic logic [15:0] axis_word(input flag_pkg::axis_state_type a, input logic at_ref);
		logic [15:0] w;
		w = flag_pkg::WORD_RESET;
		w[flag_pkg::AX_REF_ORIGIN_BIT] = at_ref; // RULE_21
		w[flag_pkg::AX_BUSY_BIT] = a.busy; // RULE_21
		w[flag_pkg::AX_SERVO_LOCK_BIT] = a.servo_lock; // RULE_21
		w[flag_pkg::AX_NO_ORIGIN_BIT] = a.no_origin; // RULE_21
		w[flag_pkg::AX_OPERATING_BIT] = a.operating; // RULE_21
		w[flag_pkg::AX_POS_DONE_BIT] = a.pos_done; // RULE_21
		return w;
	endfunction : axis_word

	logic [1:0] ref_flag;
	logic wr_en;
	logic rd_en;
	logic [7:0] reg_idx;
	logic [31:0] rd_data;
	logic idx_ok;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ref_flag[i] = axis_event_in[i].at_ref_origin & axis_event_in[i].in_position; // RULE_06
		end
		reg_idx = paddr_in[9:2];
		wr_en = psel_in & penable_in & pwrite_in;
		rd_en = psel_in & ~pwrite_in;
		idx_ok = 1'b1;
		rd_data = 32'h0000_0000;
		unique case (reg_idx)
			flag_pkg::TASK1_STATUS_IDX: rd_data = {16'h0000, task_word(cur_ff.tsk[0])};
			flag_pkg::TASK2_STATUS_IDX: rd_data = {16'h0000, task_word(cur_ff.tsk[1])};
			flag_pkg::AXIS1_STATUS_IDX: rd_data = {16'h0000, axis_word(cur_ff.ax[0], ref_flag[0])};
			flag_pkg::AXIS2_STATUS_IDX: rd_data = {16'h0000, axis_word(cur_ff.ax[1], ref_flag[1])};
			flag_pkg::TASK1_CTRL_IDX: rd_data = cur_ff.tctrl[0];
			flag_pkg::TASK2_CTRL_IDX: rd_data = cur_ff.tctrl[1];
			flag_pkg::AXIS1_CTRL_IDX: rd_data = cur_ff.actrl[0];
			flag_pkg::AXIS2_CTRL_IDX: rd_data = cur_ff.actrl[1];
			flag_pkg::CONFIG_IDX: rd_data = cur_ff.cfg;
			flag_pkg::ERROR_IDX: rd_data = {26'h0, cur_ff.refused, cur_ff.servo_off_err,
				cur_ff.origin_ret_err};
			default: idx_ok = 1'b0;
		endcase
	end

	always_comb begin
		logic [31:0] tc;
		logic [31:0] ac;
		logic teach_rise;
		logic addr_rise;
		logic [10:0] taddr;
		logic pos_over;
		logic any_cmd_rise;
		logic cmd_bit;
		logic start_pos;
		logic is_abs;
		logic [15:0] cmd_rise;
		nxt_cur = cur_ff;
		tc = 32'h0000_0000;
		ac = 32'h0000_0000;
		teach_rise = 1'b0;
		addr_rise = 1'b0;
		taddr = 11'h000;
		pos_over = 1'b0;
		any_cmd_rise = 1'b0;
		cmd_bit = 1'b0;
		start_pos = 1'b0;
		is_abs = 1'b0;
		cmd_rise = 16'h0000;
		// apb register writes
		if (wr_en) begin
			unique case (reg_idx)
				flag_pkg::TASK1_CTRL_IDX: nxt_cur.tctrl[0] = pwdata_in;
				flag_pkg::TASK2_CTRL_IDX: nxt_cur.tctrl[1] = pwdata_in;
				flag_pkg::AXIS1_CTRL_IDX: nxt_cur.actrl[0] = pwdata_in;
				flag_pkg::AXIS2_CTRL_IDX: nxt_cur.actrl[1] = pwdata_in;
				flag_pkg::CONFIG_IDX: nxt_cur.cfg = pwdata_in;
				flag_pkg::ERROR_IDX: begin
					// write one to clear error bits
					nxt_cur.origin_ret_err = cur_ff.origin_ret_err & ~pwdata_in[1:0];
					nxt_cur.servo_off_err = cur_ff.servo_off_err & ~pwdata_in[3:2];
					nxt_cur.refused = cur_ff.refused & ~pwdata_in[5:4];
				end
				default: ;
			endcase
		end
		pos_over = cur_ff.cfg[flag_pkg::CFG_POS_ADDR_MSB:flag_pkg::CFG_POS_ADDR_LSB] > flag_pkg::TEACH_ADDR_MAX;
		// teaching tasks act on edges of the control bits
		for (int t = 0; t < 2; t++) begin
			tc = nxt_cur.tctrl[t];
			teach_rise = tc[flag_pkg::TC_TEACH_BIT] & ~cur_ff.tctrl[t][flag_pkg::TC_TEACH_BIT];
			addr_rise = tc[flag_pkg::TC_ADDR_SET_BIT] & ~cur_ff.tctrl[t][flag_pkg::TC_ADDR_SET_BIT];
			taddr = tc[flag_pkg::TC_ADDR_MSB:flag_pkg::TC_ADDR_LSB];
			// done flags drop on the falling edge of their request bit, so error-set flags stay visible
			if (!tc[flag_pkg::TC_TEACH_BIT] && cur_ff.tctrl[t][flag_pkg::TC_TEACH_BIT])
				nxt_cur.tsk[t].teach_done = 1'b0; // RULE_23
			if (!tc[flag_pkg::TC_ADDR_SET_BIT] && cur_ff.tctrl[t][flag_pkg::TC_ADDR_SET_BIT])
				nxt_cur.tsk[t].addr_done = 1'b0;
			if (teach_rise) begin
				nxt_cur.tsk[t].teach_done = 1'b1;
				if (pos_over) begin
					nxt_cur.tsk[t].addr_over = 1'b1; // RULE_04
				end else if (cur_ff.ax[0].no_origin | cur_ff.ax[1].no_origin) begin
					nxt_cur.tsk[t].teach_err = 1'b1; // RULE_02
					nxt_cur.tsk[t].addr_done = 1'b1; // RULE_01
				end else begin
					nxt_cur.tsk[t].teach_err = 1'b0; // RULE_03
					nxt_cur.tsk[t].addr_over = 1'b0; // RULE_05
				end
			end
			if (addr_rise) begin
				nxt_cur.tsk[t].addr_done = 1'b1;
				if (taddr > flag_pkg::TEACH_ADDR_MAX) begin
					nxt_cur.tsk[t].teach_err = 1'b1; // RULE_02
					nxt_cur.tsk[t].teach_done = 1'b1; // RULE_01
				end else if (!(teach_rise && (pos_over || nxt_cur.tsk[t].teach_err))) begin
					nxt_cur.tsk[t].teach_err = 1'b0; // RULE_03
					nxt_cur.tsk[t].addr_over = 1'b0; // RULE_05
				end
			end
		end
		// axes
		for (int a = 0; a < 2; a++) begin
			ac = nxt_cur.actrl[a];
			is_abs = (a == 0) ? nxt_cur.cfg[flag_pkg::CFG_ABS_AXIS1_BIT] : nxt_cur.cfg[flag_pkg::CFG_ABS_AXIS2_BIT];
			cmd_rise = ac[15:0] & ~cur_ff.actrl[a][15:0];
			any_cmd_rise = |cmd_rise[flag_pkg::NUM_MANUAL_CMDS-1:0];
			cmd_bit = ac[cur_ff.ax[a].cmd];
			if (cur_ff.ax[a].busy) begin
				if (any_cmd_rise)
					nxt_cur.refused[a] = 1'b1; // RULE_09
				if (!cmd_bit)
					nxt_cur.ax[a].busy = 1'b0; // RULE_08
			end else begin
				for (int c = flag_pkg::NUM_MANUAL_CMDS - 1; c >= 0; c--) begin
					if (cmd_rise[c]) begin
						nxt_cur.ax[a].busy = 1'b1; // RULE_07
						nxt_cur.ax[a].cmd = flag_pkg::manual_cmd_type'(c);
					end
				end
				if (cmd_rise[flag_pkg::CMD_SERVO_LOCK])
					nxt_cur.ax[a].servo_lock = 1'b1; // RULE_10
				if (cmd_rise[flag_pkg::CMD_SERVO_FREE])
					nxt_cur.ax[a].servo_lock = 1'b0; // RULE_10
				if (cmd_rise[flag_pkg::CMD_ORIGIN_RETURN] && cur_ff.ax[a].no_origin)
					nxt_cur.origin_ret_err[a] = 1'b1; // RULE_14
				if (cmd_rise[flag_pkg::CMD_POS_PRESET] && !is_abs)
					nxt_cur.ax[a].no_origin = 1'b0; // RULE_13
			end
			// no-origin: faults win over same-cycle clears
			if (!is_abs && ((axis_event_in[a].search_ok) || axis_event_in[a].preset_done
					|| (ac[flag_pkg::AC_COORD_CHANGE_BIT] && !cur_ff.actrl[a][flag_pkg::AC_COORD_CHANGE_BIT])))
				nxt_cur.ax[a].no_origin = 1'b0; // RULE_13
			if (is_abs && axis_event_in[a].abs_read_ok)
				nxt_cur.ax[a].no_origin = 1'b0; // RULE_13
			// power-up origin method is known once the first configuration arrives
			if (cur_ff.pon_pending && nxt_cur.cfg[flag_pkg::CFG_ORIGIN_AT_PON_BIT] && !is_abs)
				nxt_cur.ax[a].no_origin = 1'b0; // RULE_13
			if ((is_abs && axis_event_in[a].abs_read_fail) || axis_event_in[a].search_fault
					|| (ac[flag_pkg::AC_UNDEFINE_BIT] && !cur_ff.actrl[a][flag_pkg::AC_UNDEFINE_BIT]))
				nxt_cur.ax[a].no_origin = 1'b1; // RULE_12
			// positioning start
			start_pos = ac[flag_pkg::AC_START_POS_BIT] & ~cur_ff.actrl[a][flag_pkg::AC_START_POS_BIT];
			nxt_cur.ax[a].operating = axis_event_in[a].moving; // RULE_15
			if (start_pos) begin
				if (!cur_ff.ax[a].servo_lock) begin
					nxt_cur.servo_off_err[a] = 1'b1; // RULE_11
				end else begin
					nxt_cur.ax[a].positioning = 1'b1;
					nxt_cur.ax[a].operating = 1'b1; // RULE_20
					nxt_cur.ax[a].pos_done = 1'b0; // RULE_20
				end
			end else if (cur_ff.ax[a].positioning && axis_event_in[a].in_position
					&& (axis_event_in[a].target_reached || axis_event_in[a].interrupted)) begin
				nxt_cur.ax[a].pos_done = 1'b1; // RULE_16 RULE_18 RULE_17
				nxt_cur.ax[a].positioning = 1'b0;
			end else if (cur_ff.ax[a].busy && cur_ff.ax[a].cmd == flag_pkg::CMD_PULSE_GEN
					&& axis_event_in[a].in_position) begin
				nxt_cur.ax[a].pos_done = 1'b1; // RULE_19
			end
			if (cur_ff.ax[a].positioning && axis_event_in[a].interrupted && !axis_event_in[a].in_position)
				nxt_cur.ax[a].positioning = 1'b0;
		end
		nxt_cur.pon_pending = cur_ff.pon_pending & ~(wr_en & (reg_idx == flag_pkg::CONFIG_IDX));
		// apb answer: one wait-free access phase
		nxt_cur.resp.pready = psel_in & ~penable_in;
		nxt_cur.resp.pslverr = psel_in & ~penable_in & ~idx_ok;
		if (rd_en && !penable_in)
			nxt_cur.resp.prdata = rd_data;
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			cur_ff <= '0;
			cur_ff.pon_pending <= 1'b1;
			cur_ff.ax[0].no_origin <= 1'b1; // RULE_12
			cur_ff.ax[1].no_origin <= 1'b1; // RULE_12
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign pready_out = cur_ff.resp.pready;
	assign prdata_out = cur_ff.resp.prdata;
	assign pslverr_out = cur_ff.resp.pslverr;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			run_cmd_out[i] = cur_ff.ax[i].servo_lock; // RULE_10
			servo_loop_out[i] = cur_ff.ax[i].servo_lock;
		end
	end
endmodule : status_flags

/* dv/motion_core_model.sv */
// motion core model: per-axis event source feeding the flag block
`timescale 1ns/1ps
module motion_core_model (
	// clock
	input wire logic clk_in,
	// drive state from the block
	input wire logic [1:0] run_cmd_in,
	// events to the block
	output flag_pkg::axis_event_type ev_out [2]
);
	flag_pkg::axis_event_type req [2];
	initial begin
		req[0] = 10'h000;
		req[1] = 10'h000;
		ev_out[0] = 10'h000;
		ev_out[1] = 10'h000;
	end
	// no movement without the run command to the drive
	always @(posedge clk_in) begin
		for (int a = 0; a < 2; a++) begin
			ev_out[a] <= req[a];
			ev_out[a].moving <= req[a].moving & run_cmd_in[a];
		end
	end
	// pulse fields last one cycle, levels persist; returns once the flags have settled
	task automatic put(input int a, input flag_pkg::axis_event_type e);
		req[a] <= e;
		@(posedge clk_in);
		req[a] <= e & 10'h340;
		repeat (2) @(posedge clk_in);
	endtask : put
endmodule : motion_core_model

/* dv/status_flags_sva.sv */
// checker: bus answer and status-word relations at the flag block ports
`timescale 1ns/1ps
module status_flags_sva (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// apb
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic pready_out,
	input wire logic [31:0] prdata_out,
	input wire logic pslverr_out,
	// motion core and drive
	input flag_pkg::axis_event_type axis_event_in [2],
	input wire logic [1:0] run_cmd_out,
	input wire logic [1:0] servo_loop_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_setup; psel_in && !penable_in; endsequence
	sequence s_read(logic [7:0] idx); pready_out && !pwrite_in && paddr_in[9:2] == idx; endsequence
	property p_answer; s_setup |=> pready_out ##1 !pready_out; endproperty
	property p_err_ready; pslverr_out |-> pready_out; endproperty
	property p_unmapped_zero; pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0; endproperty
	property p_drive_pair; run_cmd_out == servo_loop_out; endproperty
	property p_ax1_layout; s_read(flag_pkg::AXIS1_STATUS_IDX) |-> !pslverr_out && prdata_out[31:6] == 26'h0; endproperty
	property p_ax2_layout; s_read(flag_pkg::AXIS2_STATUS_IDX) |-> !pslverr_out && prdata_out[31:6] == 26'h0; endproperty
	property p_task_layout;
		s_read(flag_pkg::TASK2_STATUS_IDX) |-> prdata_out[11:0] == 12'h0 && prdata_out[31:16] == 16'h0;
	endproperty
	property p_lock_read;
		s_read(flag_pkg::AXIS1_STATUS_IDX) ##0 $stable(run_cmd_out[0]) |-> prdata_out[2] == $past(run_cmd_out[0]);
	endproperty
	property p_ref_origin;
		s_read(flag_pkg::AXIS1_STATUS_IDX) |->
			prdata_out[0] == $past(axis_event_in[0].at_ref_origin && axis_event_in[0].in_position);
	endproperty
	a_answer: assert property (p_answer) else $error("no single-cycle answer after setup");
	a_err_ready: assert property (p_err_ready) else $error("error flag without ready");
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
	a_drive_pair: assert property (p_drive_pair) else $error("run and loop outputs differ");
	a_ax1_layout: assert property (p_ax1_layout) else $error("axis1 word layout");
	a_ax2_layout: assert property (p_ax2_layout) else $error("axis2 word layout");
	a_task_layout: assert property (p_task_layout) else $error("task2 word layout");
	a_lock_read: assert property (p_lock_read) else $error("servo lock bit differs from drive");
	a_ref_origin: assert property (p_ref_origin) else $error("reference origin bit wrong");
endmodule : status_flags_sva
bind status_flags status_flags_sva chk (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out), .axis_event_in(axis_event_in),
	.run_cmd_out(run_cmd_out), .servo_loop_out(servo_loop_out));

/* dv/test_status_flags.sv */
// testbench: register-level tests of the status-flag block
`timescale 1ns/1ps
module test_status_flags;
	logic clk_in;
	logic reset_n_in;
	logic psel_in;
	logic penable_in;
	logic pwrite_in;
	logic [31:0] paddr_in;
	logic [31:0] pwdata_in;
	logic pready_out;
	logic [31:0] prdata_out;
	logic pslverr_out;
	flag_pkg::axis_event_type ev [2];
	logic [1:0] run_cmd_out;
	logic [1:0] servo_loop_out;
	logic [31:0] rd;
	logic er;
	int miscompares;
	int n_tests;
	status_flags dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
		.prdata_out(prdata_out), .pslverr_out(pslverr_out), .axis_event_in(ev), .run_cmd_out(run_cmd_out),
		.servo_loop_out(servo_loop_out));
	motion_core_model core (.clk_in(clk_in), .run_cmd_in(run_cmd_out), .ev_out(ev));
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= {22'h0, idx, 2'h0};
		pwdata_in <= wd;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready_out !== 1'b1);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask : apb
	task automatic rc(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		cmp(rd & mask, exp);
	endtask : rc
	initial begin
		repeat (5000) @(posedge clk_in);
		miscompares++;
		final_report();
	end
	initial begin
		miscompares = 0;
		n_tests = 0;
		reset_n_in = 1'b0;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 32'h0;
		pwdata_in = 32'h0;
		repeat (6) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'hFFFFFFFF, 32'h00000008);
		rc(flag_pkg::AXIS2_STATUS_IDX, 32'hFFFFFFFF, 32'h00000008);
		apb(1'b1, flag_pkg::AXIS1_STATUS_IDX, 32'h0000FFFF);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'hFFFFFFFF, 32'h00000008);
		apb(1'b0, 8'h30, 32'h0);
		cmp({31'h0, er}, 32'h00000001);
		$display("test reset and map done");
		apb(1'b1, flag_pkg::TASK1_CTRL_IDX, 32'h00000001);
		rc(flag_pkg::TASK1_STATUS_IDX, 32'h0000F000, 32'h00007000);
		apb(1'b1, flag_pkg::TASK1_CTRL_IDX, 32'h0);
		rc(flag_pkg::TASK1_STATUS_IDX, 32'h00006000, 32'h00004000);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h00000020);
		apb(1'b1, flag_pkg::AXIS2_CTRL_IDX, 32'h00000020);
		core.put(0, 10'h001);
		core.put(1, 10'h001);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h0000000A, 32'h00000002);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h00000024);
		rc(flag_pkg::ERROR_IDX, 32'h00000030, 32'h00000010);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h0);
		apb(1'b1, flag_pkg::AXIS2_CTRL_IDX, 32'h0);
		rc(flag_pkg::AXIS2_STATUS_IDX, 32'h0000000A, 32'h00000000);
		apb(1'b1, flag_pkg::ERROR_IDX, 32'h0000003F);
		rc(flag_pkg::ERROR_IDX, 32'h0000003F, 32'h00000000);
		$display("test busy and origin done");
		apb(1'b1, flag_pkg::TASK1_CTRL_IDX, 32'h00000001);
		rc(flag_pkg::TASK1_STATUS_IDX, 32'h0000E000, 32'h00002000);
		apb(1'b1, flag_pkg::TASK1_CTRL_IDX, 32'h07D00002);
		rc(flag_pkg::TASK1_STATUS_IDX, 32'h00007000, 32'h00007000);
		apb(1'b1, flag_pkg::TASK1_CTRL_IDX, 32'h0);
		apb(1'b1, flag_pkg::TASK1_CTRL_IDX, 32'h07CF0002);
		rc(flag_pkg::TASK1_STATUS_IDX, 32'h00005000, 32'h00001000);
		apb(1'b1, flag_pkg::TASK1_CTRL_IDX, 32'h0);
		apb(1'b1, flag_pkg::CONFIG_IDX, 32'h000007D0);
		apb(1'b1, flag_pkg::TASK2_CTRL_IDX, 32'h00000001);
		rc(flag_pkg::TASK2_STATUS_IDX, 32'h0000F000, 32'h0000A000);
		apb(1'b1, flag_pkg::TASK2_CTRL_IDX, 32'h0);
		apb(1'b1, flag_pkg::CONFIG_IDX, 32'h0);
		apb(1'b1, flag_pkg::TASK2_CTRL_IDX, 32'h00000001);
		rc(flag_pkg::TASK2_STATUS_IDX, 32'h0000C000, 32'h00000000);
		$display("test teaching done");
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h00010000);
		rc(flag_pkg::ERROR_IDX, 32'h0000000C, 32'h00000004);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h00000008);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000004, 32'h00000004);
		cmp({30'h0, run_cmd_out}, 32'h00000001);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h0);
		core.put(0, 10'h040);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h00010000);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000030, 32'h00000010);
		core.put(0, 10'h180);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000030, 32'h00000020);
		core.put(0, 10'h000);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000020, 32'h00000020);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h0);
		core.put(0, 10'h040);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h00010000);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000030, 32'h00000010);
		core.put(0, 10'h120);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000030, 32'h00000020);
		core.put(0, 10'h300);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000001, 32'h00000001);
		core.put(0, 10'h200);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000001, 32'h00000000);
		$display("test servo and positioning done");
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h0);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h00010000);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000020, 32'h00000000);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h00000100);
		core.put(0, 10'h100);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000022, 32'h00000022);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h00020000);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h0000000A, 32'h00000008);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h00000002);
		rc(flag_pkg::ERROR_IDX, 32'h00000003, 32'h00000001);
		$display("test pulse generator and no origin done");
		reset_n_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		reset_n_in <= 1'b1;
		@(posedge clk_in);
		apb(1'b1, flag_pkg::CONFIG_IDX, 32'h00050000);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000008, 32'h00000000);
		rc(flag_pkg::AXIS2_STATUS_IDX, 32'h00000008, 32'h00000008);
		core.put(1, 10'h004);
		rc(flag_pkg::AXIS2_STATUS_IDX, 32'h00000008, 32'h00000000);
		core.put(1, 10'h002);
		rc(flag_pkg::AXIS2_STATUS_IDX, 32'h00000008, 32'h00000008);
		core.put(0, 10'h008);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000008, 32'h00000008);
		core.put(0, 10'h010);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000008, 32'h00000000);
		core.put(0, 10'h008);
		apb(1'b1, flag_pkg::AXIS1_CTRL_IDX, 32'h00040000);
		rc(flag_pkg::AXIS1_STATUS_IDX, 32'h00000008, 32'h00000000);
		$display("test origin sources done");
		final_report();
	end
endmodule : test_status_flags
